/* amc_map.svh */
// offsets, field positions, reset values and timing counts of the motion control word block
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH
`define AMC_OFS_LOOP_LEN   8'h1f
`define AMC_OFS_SPD_CCW    8'h20
`define AMC_OFS_SPD_CW     8'h21
`define AMC_OFS_STEP       8'h22
`define AMC_OFS_HOLD       8'h23
`define AMC_OFS_CMD        8'h24
`define AMC_RST_LOOP_LEN   32'h0000_00fa
`define AMC_RST_SPD        16'h0000
`define AMC_RST_STEP       16'h0001
`define AMC_RST_HOLD       16'h00c8
`define AMC_RST_CMD        16'h0000
`define AMC_CMD_MAN_FWD    0
`define AMC_CMD_MAN_REV    1
`define AMC_CMD_XFER       2
`define AMC_CMD_JOG_CONT   3
`define AMC_CMD_RELEASE    4
`define AMC_CMD_KEY_EN     5
`define AMC_CMD_NO_LOOP    6
`define AMC_CMD_REF_LOOP   7
`define AMC_CMD_JOG_FWD    8
`define AMC_CMD_JOG_REV    9
`define AMC_CMD_READJ      10
`define AMC_CMD_BRK_FREE   11
`define AMC_CMD_DRAG_COR   12
`define AMC_CMD_USED_MASK  16'h1fff
`define AMC_HOLD_UNIT_NS   5000000
`define AMC_CLK_PERIOD_NS  10
`define AMC_HOLD_UNIT_CYC  (`AMC_HOLD_UNIT_NS / `AMC_CLK_PERIOD_NS)
`endif

/* amc_pkg.sv */
// types of the motion control word block
package amc_pkg;
  typedef enum logic [1:0] {
    AMC_DIR_NONE,
    AMC_DIR_FWD,
    AMC_DIR_REV
  } amc_dir_t;
  typedef enum logic [2:0] {
    AMC_RUN_IDLE,
    AMC_RUN_STEP,
    AMC_RUN_HOLD,
    AMC_RUN_CONT
  } amc_jog_t;
endpackage

/* amc_jog_if.sv */
// request and answer signals between the top and the jog timer
`timescale 1ns/100ps
interface amc_jog_if;
  logic        req;
  logic [15:0] hold_units;
  logic        cont_allowed;
  logic        step_pulse;
  logic        cont_run;
  modport timer (input req, input hold_units, input cont_allowed, output step_pulse, output cont_run);
  modport user  (output req, output hold_units, output cont_allowed, input step_pulse, input cont_run);
endinterface

/* amc_jog_timer.sv */
// hold-time qualifier that splits a jog request into a single step or a continuous run
`timescale 1ns/100ps
`include "amc_map.svh"
module amc_jog_timer
  import amc_pkg::*;
#(
  parameter int UNIT_CYC = `AMC_HOLD_UNIT_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  amc_jog_if.timer  jog
);
  // refused at elaboration, a zero prescaler never advances
  if (UNIT_CYC < 1) begin : g_unit_chk
    $error("unit count must be at least one");
  end

  amc_jog_t    st_reg, st_next;
  logic [31:0] pre_reg, pre_next;
  logic [15:0] units_reg, units_next;
  logic        step_reg, step_next;

  always_comb begin
    st_next    = st_reg;
    pre_next   = pre_reg;
    units_next = units_reg;
    step_next  = 1'b0;
    unique case (st_reg)
      AMC_RUN_IDLE: begin
        pre_next   = 32'h0;
        units_next = 16'h0;
        if (jog.req) begin
          st_next = AMC_RUN_HOLD;
        end
      end
      AMC_RUN_HOLD: begin
        if (!jog.req) begin
          st_next = AMC_RUN_STEP;
        end else if (units_reg >= jog.hold_units && jog.cont_allowed) begin
          st_next = AMC_RUN_CONT;
        end else if (pre_reg == 32'(UNIT_CYC - 1)) begin
          pre_next = 32'h0;
          if (units_reg != 16'hffff) begin
            units_next = units_reg + 16'h1;
          end
        end else begin
          pre_next = pre_reg + 32'h1;
        end
      end
      AMC_RUN_STEP: begin
        step_next = 1'b1;
        st_next   = AMC_RUN_IDLE;
      end
      AMC_RUN_CONT: begin
        if (!jog.req || !jog.cont_allowed) begin
          st_next = AMC_RUN_IDLE;
        end
      end
      // unused state codes fall back to idle
      default: begin
        st_next = AMC_RUN_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg    <= AMC_RUN_IDLE;
      pre_reg   <= 32'h0;
      units_reg <= 16'h0;
      step_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      pre_reg   <= pre_next;
      units_reg <= units_next;
      step_reg  <= step_next;
    end
  end

  assign jog.step_pulse = step_reg;
  assign jog.cont_run   = (st_reg == AMC_RUN_CONT);

  cont_after_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(jog.cont_run) |-> $past(st_reg) == AMC_RUN_HOLD && $past(units_reg) >= $past(jog.hold_units))
    else $error("continuous run began before the hold time");

  sequence hold_left_s;
    st_reg == AMC_RUN_HOLD && !jog.req;
  endsequence
  sequence step_out_s;
    ##2 jog.step_pulse;
  endsequence
  step_after_a: assert property (@(posedge core_clk) disable iff (rst) hold_left_s |-> step_out_s)
    else $error("short jog gave no single step");
endmodule

/* amc_motion_ctrl.sv */
// motion command word and parameter registers with run gating
`timescale 1ns/100ps
`include "amc_map.svh"
module amc_motion_ctrl
  import amc_pkg::*;
#(
  parameter int UNIT_CYC = `AMC_HOLD_UNIT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        attr_wr,
  input  wire logic        attr_rd,
  input  wire logic [7:0]  attr_num,
  input  wire logic [31:0] attr_wdata,
  output logic      [31:0] attr_rdata,
  output logic             attr_ack,
  output logic             attr_err,
  input  wire logic        poll_target_valid,
  input  wire logic [15:0] poll_cmd,
  input  wire logic        bus_connected,
  input  wire logic        key_fwd_pin,
  input  wire logic        key_rev_pin,
  output logic             move_fwd,
  output logic             move_rev,
  output logic             step_fwd,
  output logic             step_rev,
  output logic [15:0]      step_count,
  output logic             pos_start,
  output logic [31:0]      approach_loop,
  output logic             ref_loop_start,
  output logic             readjust_en,
  output logic             brake_free_start,
  output logic             drag_correct_en
);
  // refused at elaboration, a zero prescaler never advances
  if (UNIT_CYC < 1) begin : g_unit_chk
    $error("unit count must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] loop_reg, loop_next;
  logic [15:0] ccw_reg, ccw_next, cw_reg, cw_next;
  logic [15:0] step_reg, step_next;
  logic [15:0] hold_reg, hold_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next, err_reg, err_next;

  always_comb begin
    loop_next  = loop_reg;
    ccw_next   = ccw_reg;
    cw_next    = cw_reg;
    step_next  = step_reg;
    hold_next  = hold_reg;
    cmd_next   = cmd_reg;
    rdata_next = rdata_reg;
    ack_next   = attr_wr | attr_rd;
    err_next   = 1'b0;
    if (attr_wr) begin
      unique case (attr_num)
        `AMC_OFS_LOOP_LEN: loop_next = attr_wdata;
        `AMC_OFS_SPD_CCW:  ccw_next  = attr_wdata[15:0];
        `AMC_OFS_SPD_CW:   cw_next   = attr_wdata[15:0];
        `AMC_OFS_STEP:     step_next = attr_wdata[15:0];
        `AMC_OFS_HOLD:     hold_next = attr_wdata[15:0];
        `AMC_OFS_CMD:      cmd_next  = attr_wdata[15:0] & `AMC_CMD_USED_MASK;
        default:           err_next  = 1'b1;
      endcase
    end else if (poll_target_valid) begin
      // poll data carries the command word too
      cmd_next = poll_cmd & `AMC_CMD_USED_MASK;
    end
    if (attr_rd) begin
      unique case (attr_num)
        `AMC_OFS_LOOP_LEN: rdata_next = loop_reg;
        `AMC_OFS_SPD_CCW:  rdata_next = {16'h0, ccw_reg};
        `AMC_OFS_SPD_CW:   rdata_next = {16'h0, cw_reg};
        `AMC_OFS_STEP:     rdata_next = {16'h0, step_reg};
        `AMC_OFS_HOLD:     rdata_next = {16'h0, hold_reg};
        `AMC_OFS_CMD:      rdata_next = {16'h0, cmd_reg};
        default: begin
          rdata_next = 32'h0;
          err_next   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loop_reg  <= `AMC_RST_LOOP_LEN;
      ccw_reg   <= `AMC_RST_SPD;
      cw_reg    <= `AMC_RST_SPD;
      step_reg  <= `AMC_RST_STEP;
      hold_reg  <= `AMC_RST_HOLD;
      cmd_reg   <= `AMC_RST_CMD;
      rdata_reg <= 32'h0;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      loop_reg  <= loop_next;
      ccw_reg   <= ccw_next;
      cw_reg    <= cw_next;
      step_reg  <= step_next;
      hold_reg  <= hold_next;
      cmd_reg   <= cmd_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key synchronisers; first stage feeds only the second
  logic [1:0] kf_sync_reg, kr_sync_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      kf_sync_reg <= 2'h0;
      kr_sync_reg <= 2'h0;
    end else begin
      kf_sync_reg <= {kf_sync_reg[0], key_fwd_pin};
      kr_sync_reg <= {kr_sync_reg[0], key_rev_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // jog requests
  logic keys_on, jog_fwd_req, jog_rev_req;
  always_comb begin
    keys_on = !bus_connected || cmd_reg[`AMC_CMD_KEY_EN];
    jog_fwd_req = (keys_on && kf_sync_reg[1]) || cmd_reg[`AMC_CMD_JOG_FWD];
    jog_rev_req = (keys_on && kr_sync_reg[1]) || cmd_reg[`AMC_CMD_JOG_REV];
  end

  amc_jog_if jf_if ();
  amc_jog_if jr_if ();
  assign jf_if.req          = jog_fwd_req && !jog_rev_req;
  assign jf_if.hold_units   = hold_reg;
  assign jf_if.cont_allowed = cmd_reg[`AMC_CMD_JOG_CONT];
  assign jr_if.req          = jog_rev_req && !jog_fwd_req;
  assign jr_if.hold_units   = hold_reg;
  assign jr_if.cont_allowed = cmd_reg[`AMC_CMD_JOG_CONT];

  amc_jog_timer #(.UNIT_CYC(UNIT_CYC)) u_jog_fwd (
    .core_clk (core_clk),
    .rst      (rst),
    .jog      (jf_if.timer)
  );
  amc_jog_timer #(.UNIT_CYC(UNIT_CYC)) u_jog_rev (
    .core_clk (core_clk),
    .rst      (rst),
    .jog      (jr_if.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // run gating outputs
  logic        rel;
  logic        mf_reg, mf_next, mr_reg, mr_next;
  logic        sf_reg, sf_next, sr_reg, sr_next;
  logic        ps_reg, ps_next, rl_reg, rl_next, bf_reg, bf_next;
  logic        ra_reg, ra_next, dc_reg, dc_next;
  logic [31:0] al_reg, al_next;
  logic        ref_prev_reg, ref_prev_next, bf_prev_reg, bf_prev_next;

  always_comb begin
    rel = cmd_reg[`AMC_CMD_RELEASE];
    mf_next = (rel && cmd_reg[`AMC_CMD_MAN_FWD] && !cmd_reg[`AMC_CMD_MAN_REV]) || jf_if.cont_run;
    mr_next = (rel && cmd_reg[`AMC_CMD_MAN_REV] && !cmd_reg[`AMC_CMD_MAN_FWD]) || jr_if.cont_run;
    sf_next = jf_if.step_pulse;
    sr_next = jr_if.step_pulse;
    ps_next = poll_target_valid && poll_cmd[`AMC_CMD_XFER] && poll_cmd[`AMC_CMD_RELEASE];
    al_next = cmd_reg[`AMC_CMD_NO_LOOP] ? 32'h0 : loop_reg;
    ref_prev_next = rel && cmd_reg[`AMC_CMD_REF_LOOP];
    rl_next       = ref_prev_next && !ref_prev_reg;
    bf_prev_next = rel && cmd_reg[`AMC_CMD_BRK_FREE];
    bf_next      = bf_prev_next && !bf_prev_reg;
    ra_next = cmd_reg[`AMC_CMD_READJ];
    dc_next = cmd_reg[`AMC_CMD_DRAG_COR];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mf_reg       <= 1'b0;
      mr_reg       <= 1'b0;
      sf_reg       <= 1'b0;
      sr_reg       <= 1'b0;
      ps_reg       <= 1'b0;
      al_reg       <= `AMC_RST_LOOP_LEN;
      rl_reg       <= 1'b0;
      bf_reg       <= 1'b0;
      ra_reg       <= 1'b0;
      dc_reg       <= 1'b0;
      ref_prev_reg <= 1'b0;
      bf_prev_reg  <= 1'b0;
    end else begin
      mf_reg       <= mf_next;
      mr_reg       <= mr_next;
      sf_reg       <= sf_next;
      sr_reg       <= sr_next;
      ps_reg       <= ps_next;
      al_reg       <= al_next;
      rl_reg       <= rl_next;
      bf_reg       <= bf_next;
      ra_reg       <= ra_next;
      dc_reg       <= dc_next;
      ref_prev_reg <= ref_prev_next;
      bf_prev_reg  <= bf_prev_next;
    end
  end

  assign attr_rdata       = rdata_reg;
  assign attr_ack         = ack_reg;
  assign attr_err         = err_reg;
  assign move_fwd         = mf_reg;
  assign move_rev         = mr_reg;
  assign step_fwd         = sf_reg;
  assign step_rev         = sr_reg;
  assign step_count       = step_reg;
  assign pos_start        = ps_reg;
  assign approach_loop    = al_reg;
  assign ref_loop_start   = rl_reg;
  assign readjust_en      = ra_reg;
  assign brake_free_start = bf_reg;
  assign drag_correct_en  = dc_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence poll_go_s;
    poll_target_valid && poll_cmd[`AMC_CMD_XFER] && poll_cmd[`AMC_CMD_RELEASE];
  endsequence
  sequence start_s;
    ##1 pos_start;
  endsequence

  poll_start_a: assert property (@(posedge core_clk) disable iff (rst) poll_go_s |-> start_s)
    else $error("poll target with transfer bit did not start");
  poll_block_a: assert property (@(posedge core_clk) disable iff (rst)
    pos_start |-> $past(poll_cmd[`AMC_CMD_XFER]) && $past(poll_target_valid))
    else $error("positioning started without transfer bit");
  man_release_a: assert property (@(posedge core_clk) disable iff (rst)
    (move_fwd && !$past(jf_if.cont_run)) |-> $past(cmd_reg[`AMC_CMD_RELEASE]))
    else $error("manual run without release");
  loop_skip_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(cmd_reg[`AMC_CMD_NO_LOOP]) |-> approach_loop == 32'h0)
    else $error("approach loop used while bypass set");
  loop_len_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(cmd_reg[`AMC_CMD_NO_LOOP]) |-> approach_loop == $past(loop_reg))
    else $error("approach loop differs from programmed length");
  key_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (bus_connected && !cmd_reg[`AMC_CMD_KEY_EN] && !cmd_reg[`AMC_CMD_JOG_FWD]) |-> !jog_fwd_req)
    else $error("external key honoured while gated");
  jog_cont_a: assert property (@(posedge core_clk) disable iff (rst)
    !cmd_reg[`AMC_CMD_JOG_CONT] |=> !jf_if.cont_run)
    else $error("continuous jog without bit3");
  readjust_a: assert property (@(posedge core_clk) disable iff (rst)
    readjust_en == $past(cmd_reg[`AMC_CMD_READJ]))
    else $error("readjust enable mismatch");
  brake_rel_a: assert property (@(posedge core_clk) disable iff (rst)
    brake_free_start |-> $past(cmd_reg[`AMC_CMD_BRK_FREE]) && $past(rel))
    else $error("braking-free run without release");
  cmd_reset_a: assert property (@(posedge core_clk) $fell(rst) |-> cmd_reg == 16'h0)
    else $error("command word not zero after reset");
endmodule

/* amc_master_model.sv */
// fieldbus master model: attribute accesses and poll frames
`timescale 1ns/100ps
module amc_master_model (
  input  wire logic        core_clk,
  output logic             attr_wr,
  output logic             attr_rd,
  output logic [7:0]       attr_num,
  output logic [31:0]      attr_wdata,
  input  wire logic [31:0] attr_rdata,
  input  wire logic        attr_ack,
  input  wire logic        attr_err,
  output logic             poll_target_valid,
  output logic [15:0]      poll_cmd
);
  initial begin
    attr_wr = 1'b0;
    attr_rd = 1'b0;
    attr_num = 8'h00;
    attr_wdata = 32'h0;
    poll_target_valid = 1'b0;
    poll_cmd = 16'h0;
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle strobe; answer taken with ack, then released
  task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ack, output logic err);
    @(posedge core_clk);
    #1;
    attr_wr = wr;
    attr_rd = !wr;
    attr_num = num;
    attr_wdata = wd;
    @(posedge core_clk);
    #1;
    rd = attr_rdata;
    ack = attr_ack;
    err = attr_err;
    attr_wr = 1'b0;
    attr_rd = 1'b0;
    // released data shows garbage, not the last value
    attr_wdata = ~wd;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic poll(input logic [15:0] cmd, input logic exec);
    @(posedge core_clk);
    #1;
    poll_target_valid = 1'b1;
    poll_cmd = cmd & 16'h1fff;
    poll_cmd[2] = exec;
    @(posedge core_clk);
    #1;
    poll_target_valid = 1'b0;
    poll_cmd = ~poll_cmd;
  endtask
endmodule

/* testbench.sv */
// self-checking bench of the motion control word block
`timescale 1ns/100ps
`include "amc_map.svh"
module testbench;
  import amc_pkg::*;
  logic        core_clk, rst, bus_connected, key_fwd_pin, key_rev_pin;
  logic        attr_wr, attr_rd, attr_ack, attr_err, poll_target_valid;
  logic [7:0]  attr_num;
  logic [31:0] attr_wdata, attr_rdata, approach_loop, d, lp;
  logic [15:0] poll_cmd, step_count, c;
  logic        move_fwd, move_rev, step_fwd, step_rev, pos_start;
  logic        ref_loop_start, readjust_en, brake_free_start, drag_correct_en;
  int          num_errors, n_compared, seed, cycles, pc[5], snap[5];
  logic [15:0] mtab[5] = '{16'h0011, 16'h0012, 16'h0013, 16'h0001, 16'h0002};

  amc_motion_ctrl #(.UNIT_CYC(4)) i_dut (.core_clk(core_clk), .rst(rst), .attr_wr(attr_wr), .attr_rd(attr_rd),
    .attr_num(attr_num), .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .attr_ack(attr_ack),
    .attr_err(attr_err), .poll_target_valid(poll_target_valid), .poll_cmd(poll_cmd),
    .bus_connected(bus_connected), .key_fwd_pin(key_fwd_pin), .key_rev_pin(key_rev_pin),
    .move_fwd(move_fwd), .move_rev(move_rev), .step_fwd(step_fwd), .step_rev(step_rev),
    .step_count(step_count), .pos_start(pos_start), .approach_loop(approach_loop),
    .ref_loop_start(ref_loop_start), .readjust_en(readjust_en), .brake_free_start(brake_free_start),
    .drag_correct_en(drag_correct_en));
  amc_master_model i_master (.core_clk(core_clk), .attr_wr(attr_wr), .attr_rd(attr_rd), .attr_num(attr_num),
    .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .attr_ack(attr_ack), .attr_err(attr_err),
    .poll_target_valid(poll_target_valid), .poll_cmd(poll_cmd));
  ////////////////////////////////////////////////////////////////
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  // pulse counters: pos, ref, brake, step fwd, step rev
  always @(posedge core_clk) begin
    pc[0] += (pos_start === 1'b1);
    pc[1] += (ref_loop_start === 1'b1);
    pc[2] += (brake_free_start === 1'b1);
    pc[3] += (step_fwd === 1'b1);
    pc[4] += (step_rev === 1'b1);
    cycles++;
    // run is about 360 cycles; ceiling well above
    if (cycles == 8000) begin
      num_errors++;
      $display("wrong value at %0t: run hung", $time);
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] n, input logic [31:0] wd);
    logic [31:0] r;
    logic        a, e;
    i_master.access(1'b1, n, wd, r, a, e);
  endtask
  task automatic rd_chk(input logic [7:0] n, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        a, e;
    i_master.access(1'b0, n, 32'h0, r, a, e);
    chk({31'h0, a}, 32'h1, "ack");
    chk({31'h0, e}, {31'h0, exp_err}, "err");
    chk(r, exp, "rdata");
  endtask
  task automatic mark;
    snap = pc;
  endtask
  task automatic pulses(input int i, input int exp);
    chk(32'(pc[i] - snap[i]), 32'(exp), "pulse count");
  endtask
  function automatic logic [31:0] exp_move(input logic [15:0] w, input logic fwd);
    return {31'h0, w[4] & (fwd ? (w[0] & !w[1]) : (w[1] & !w[0]))};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 10614;
    rst = 1'b1;
    bus_connected = 1'b1;
    key_fwd_pin = 1'b0;
    key_rev_pin = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk(approach_loop, `AMC_RST_LOOP_LEN, "loop out");
    chk({16'h0, step_count}, 32'h1, "step out");
    rd_chk(`AMC_OFS_LOOP_LEN, `AMC_RST_LOOP_LEN, 1'b0);
    rd_chk(`AMC_OFS_SPD_CCW, 32'h0, 1'b0);
    rd_chk(`AMC_OFS_SPD_CW, 32'h0, 1'b0);
    rd_chk(`AMC_OFS_STEP, 32'h1, 1'b0);
    rd_chk(`AMC_OFS_HOLD, 32'hc8, 1'b0);
    rd_chk(`AMC_OFS_CMD, 32'h0, 1'b0);
    rd_chk(8'h25, 32'h0, 1'b1);
    $display("test reset done");
    repeat (4) begin
      lp = $random(seed);
      d = 32'(1 + ($unsigned($random(seed)) % 100));
      wr(`AMC_OFS_LOOP_LEN, lp);
      wr(`AMC_OFS_STEP, d);
      cyc(2);
      chk(approach_loop, lp, "loop out");
      chk({16'h0, step_count}, d, "step out");
      rd_chk(`AMC_OFS_LOOP_LEN, lp, 1'b0);
    end
    wr(`AMC_OFS_CMD, 32'he000);
    rd_chk(`AMC_OFS_CMD, 32'h0, 1'b0);
    wr(`AMC_OFS_HOLD, 32'h3);
    $display("test parameters done");
    foreach (mtab[i]) begin
      wr(`AMC_OFS_CMD, {16'h0, mtab[i]});
      cyc(3);
      chk({31'h0, move_fwd}, exp_move(mtab[i], 1'b1), "move fwd");
      chk({31'h0, move_rev}, exp_move(mtab[i], 1'b0), "move rev");
    end
    wr(`AMC_OFS_CMD, 32'h0);
    mark();
    wr(`AMC_OFS_CMD, 32'h0080);
    cyc(3);
    pulses(1, 0);
    wr(`AMC_OFS_CMD, 32'h0);
    wr(`AMC_OFS_CMD, 32'h1490);
    cyc(3);
    pulses(1, 1);
    chk({31'h0, readjust_en}, 32'h1, "readjust");
    chk({31'h0, drag_correct_en}, 32'h1, "drag");
    chk(approach_loop, lp, "loop kept");
    wr(`AMC_OFS_CMD, 32'h0850);
    cyc(3);
    pulses(2, 1);
    chk(approach_loop, 32'h0, "no loop");
    chk({31'h0, readjust_en}, 32'h0, "readjust");
    chk({31'h0, drag_correct_en}, 32'h0, "drag");
    $display("test command bits done");
    for (int i = 0; i < 16; i++) begin
      c = (i == 0) ? 16'h0014 : (i == 1) ? 16'h0010 : (i == 2) ? 16'h0004 : 16'($random(seed));
      mark();
      i_master.poll(c, c[2]);
      cyc(2);
      pulses(0, int'(c[2] & c[4]));
    end
    i_master.poll(16'h0, 1'b0);
    cyc(20);
    $display("test poll done");
    // short jog: one step each way, bit 4 clear
    for (int k = 0; k < 2; k++) begin
      mark();
      wr(`AMC_OFS_CMD, k ? 32'h0200 : 32'h0100);
      cyc(3);
      wr(`AMC_OFS_CMD, 32'h0);
      cyc(10);
      pulses(3, 1 - k);
      pulses(4, k);
    end
    wr(`AMC_OFS_CMD, 32'h0108);
    cyc(6);
    chk({31'h0, move_fwd}, 32'h0, "early run");
    cyc(20);
    chk({31'h0, move_fwd}, 32'h1, "cont run");
    wr(`AMC_OFS_CMD, 32'h0100);
    cyc(3);
    chk({31'h0, move_fwd}, 32'h0, "run no bit3");
    wr(`AMC_OFS_CMD, 32'h0);
    cyc(10);
    wr(`AMC_OFS_CMD, 32'h0208);
    cyc(26);
    chk({31'h0, move_rev}, 32'h1, "cont rev");
    wr(`AMC_OFS_CMD, 32'h0);
    cyc(10);
    $display("test jog done");
    // keys: cmd, bus, expected steps
    for (int k = 0; k < 3; k++) begin
      wr(`AMC_OFS_CMD, (k == 1) ? 32'h0020 : 32'h0);
      bus_connected = (k != 2);
      mark();
      key_fwd_pin = (k != 2);
      key_rev_pin = (k == 2);
      cyc(3);
      key_fwd_pin = 1'b0;
      key_rev_pin = 1'b0;
      cyc(10);
      pulses(3, int'(k == 1));
      pulses(4, int'(k == 2));
    end
    $display("test keys done");
    // mid-run reset must drop a live command word
    wr(`AMC_OFS_CMD, 32'h1490);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk({31'h0, readjust_en}, 32'h0, "readjust after reset");
    chk(approach_loop, `AMC_RST_LOOP_LEN, "loop after reset");
    rd_chk(`AMC_OFS_CMD, 32'h0, 1'b0);
    $display("test reset again done");
    end_sim();
  end
endmodule
